// [include/dsm_pkg.sv]
// Shared constants, types and register map of the dual switch mode controller.
// Assumes a 125 MHz system clock and a plain strobe register port.
package dsm_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned STBY_DELAY_US = 1000;
  localparam int unsigned RETRY_TIME_US = 1000;
  // Least times, rounded up to whole cycles
  localparam int unsigned STBY_DELAY_CYC =
    (STBY_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RETRY_CYC =
    (RETRY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] CNT_RST = 20'h00000;

  // Register byte offsets
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h08;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h0C;
  localparam logic [7:0] REG_CONFIG = 8'h10;

  // Mode register fields
  localparam int MODE_STATE_LSB = 0;
  localparam int MODE_SW_LSB = 3;
  localparam int MODE_FLT_LSB = 5;
  localparam int MODE_DIAG_BIT = 7;

  // Interrupt bit layout
  localparam int IRQ_W = 5;
  localparam int IRQ_FLT_LSB = 0;
  localparam int IRQ_RETRY_LSB = 2;
  localparam int IRQ_STBY_BIT = 4;

  // Reset values
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 5'h00;
  localparam logic [1:0] CHAN_MASK_RST = 2'h3;

  typedef enum logic [2:0] {
    DEV_STANDBY = 3'b000,
    DEV_STBY_DLY = 3'b001,
    DEV_DIAG = 3'b010,
    DEV_ACTIVE = 3'b011
  } dev_state_t;

  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_ON = 2'b01,
    CH_FAULT = 2'b10
  } chan_state_t;

  // Pin inputs after synchronisation
  typedef struct packed {
    logic latch_sel;
    logic diag_on;
    logic [1:0] chan_on_input;
    logic [1:0] thermal;
    logic [1:0] ilim;
  } pins_t;

endpackage

// [hw/chan_ctrl.sv]
// One power channel: off, on and fault with retry timer.
// Assumes synchronised inputs on the system clock.
`timescale 1ns/1ps
module chan_ctrl
  import dsm_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Channel inputs
  input wire logic chan_on_i,
  input wire logic fault_i,
  input wire logic latch_sel_i,
  // Channel outputs
  output logic switch_on_o,
  output logic in_fault_o,
  output logic fault_evt_o,
  output logic retry_evt_o
);

  chan_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_fevt, next_revt;
  logic retry_done;

  assign retry_done = (cnt == CNT_W'(RETRY_CYCLES - 1));

  // Next channel state; other channel never seen here
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_fevt = 1'b0;
    next_revt = 1'b0;
    case (state)
      CH_OFF: begin
        if (chan_on_i) begin
          next_state = CH_ON;
        end
      end
      CH_ON: begin
        if (fault_i) begin
          next_state = CH_FAULT;
          next_cnt = CNT_RST;
          next_fevt = 1'b1;
        end else if (!chan_on_i) begin
          next_state = CH_OFF;
        end
      end
      CH_FAULT: begin
        if (!retry_done) begin
          next_cnt = cnt + 1'b1;
        end
        // Latch high holds the channel off until the host drops it
        if (!fault_i && !latch_sel_i && retry_done) begin
          next_state = chan_on_i ? CH_ON : CH_OFF;
          next_revt = 1'b1;
        end
      end
      default: next_state = CH_OFF;
    endcase
  end

  // Channel registers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= CH_OFF;
      cnt <= CNT_RST;
      switch_on_o <= 1'b0;
      in_fault_o <= 1'b0;
      fault_evt_o <= 1'b0;
      retry_evt_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      switch_on_o <= (next_state == CH_ON);
      in_fault_o <= (next_state == CH_FAULT);
      fault_evt_o <= next_fevt;
      retry_evt_o <= next_revt;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  property p_fault_off;
    state == CH_ON && fault_i |=> state == CH_FAULT && !switch_on_o;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("fault did not shut channel off");

  property p_latch_hold;
    state == CH_FAULT && latch_sel_i |=> state == CH_FAULT;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("fault exited with latch high");

  property p_exit_follows_en;
    $fell(state == CH_FAULT) |-> switch_on_o == $past(chan_on_i)
      && $past(retry_done) && !$past(fault_i);
  endproperty
  a_exit_follows_en: assert property (p_exit_follows_en)
    else $error("fault exit wrong");

  property p_on_follows;
    state == CH_OFF && chan_on_i |=> switch_on_o;
  endproperty
  a_on_follows: assert property (p_on_follows)
    else $error("channel did not turn on");

  c_retry: cover property ($fell(state == CH_FAULT) && switch_on_o);

endmodule // chan_ctrl

// [hw/dual_switch_mode_controller.sv]
// Device mode controller for a two channel high side switch.
// Assumes asynchronous pins, 125 MHz clock, strobe register port.
//
// Overview of operation
// - In Standby all diagnostics stay off.
// - Diagnostic state runs diagnostics with both switches off.
// - All enables and diag enable low sends the device to Standby Delay.
// - Standby follows the delay only if all enables are still low.
// - Any enabled channel puts the device in Active.
// - In Active the diag enable turns diagnostics on and off freely.
// - A thermal or current limit shutdown puts that channel in Fault.
// - Fault ends only with faults clear, latch low, retry timer done.
// - Leaving Fault the switch turns on only if its enable is high.
// - Each channel follows its own enable input.
// - Fault and retry on one channel leave the other untouched.
`timescale 1ns/1ps
module dual_switch_mode_controller
  import dsm_pkg::*;
#(
  parameter int unsigned STBY_DELAY_CYCLES = STBY_DELAY_CYC,
  parameter int unsigned RETRY_CYCLES = RETRY_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Host pins
  input wire logic chan_one_on_i,
  input wire logic chan_two_on_i,
  input wire logic diag_on_i,
  input wire logic latch_sel_i,
  // Protection events per channel
  input wire logic [1:0] thermal_sd_i,
  input wire logic [1:0] cur_limit_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Status outputs
  output logic [1:0] switch_on_o,
  output logic [1:0] chan_fault_o,
  output logic diag_active_o,
  output logic [2:0] dev_mode_o,
  output logic irq_o
);

  // Standby and its delay share the idle exit paths
  function automatic logic dev_quiet(input dev_state_t s);
    return (s == DEV_STANDBY) || (s == DEV_STBY_DLY);
  endfunction

  pins_t pins_raw, pins_meta, pins_s;
  dev_state_t state, next_state;
  logic [CNT_W-1:0] dly_cnt, next_dly_cnt;
  logic next_diag;
  logic [1:0] en_eff, chan_flt, sw, ch_fevt, ch_revt;
  logic all_low, dly_done;
  logic [1:0] chan_mask, next_chan_mask;
  logic [IRQ_W-1:0] irq_status, next_irq_status;
  logic [IRQ_W-1:0] irq_enable, next_irq_enable;
  logic [IRQ_W-1:0] irq_evt, irq_clr;
  logic next_irq;
  logic [31:0] next_rdata;
  logic stby_evt;

  assign pins_raw = '{latch_sel: latch_sel_i, diag_on: diag_on_i,
                      chan_on_input: {chan_two_on_i, chan_one_on_i},
                      thermal: thermal_sd_i, ilim: cur_limit_i};

  // Two flop synchroniser; meta stage feeds only the second stage
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pins_meta <= '0;
      pins_s <= '0;
    end else begin
      pins_meta <= pins_raw;
      pins_s <= pins_meta;
    end
  end

  // Software mask lets the host park a channel without its pin
  assign en_eff = pins_s.chan_on_input & chan_mask;
  assign all_low = (en_eff == 2'b00) && !pins_s.diag_on;
  assign dly_done = (dly_cnt == CNT_W'(STBY_DELAY_CYCLES - 1));

  // One controller per channel, no shared state between them
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      chan_ctrl #(
        .RETRY_CYCLES(RETRY_CYCLES)
      ) u_chan (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .chan_on_i(en_eff[gi]),
        .fault_i(pins_s.thermal[gi] | pins_s.ilim[gi]),
        .latch_sel_i(pins_s.latch_sel),
        .switch_on_o(sw[gi]),
        .in_fault_o(chan_flt[gi]),
        .fault_evt_o(ch_fevt[gi]),
        .retry_evt_o(ch_revt[gi])
      );
    end
  endgenerate

  // Device mode; a channel waiting in Fault with its enable high
  // still counts as Active so the retry keeps its place
  always_comb begin
    next_state = state;
    next_dly_cnt = dly_cnt;
    if (en_eff != 2'b00) begin
      next_state = DEV_ACTIVE;
    end else if (pins_s.diag_on) begin
      next_state = DEV_DIAG;
    end else if (state == DEV_STBY_DLY) begin
      if (dly_done) begin
        next_state = DEV_STANDBY;
      end else begin
        next_dly_cnt = dly_cnt + 1'b1;
      end
    end else if (state != DEV_STANDBY) begin
      next_state = DEV_STBY_DLY;
      next_dly_cnt = CNT_RST;
    end
    // Diagnostics only where the mode allows them
    next_diag = pins_s.diag_on && !dev_quiet(next_state);
  end

  // Device mode registers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= DEV_STBY_DLY;
      dly_cnt <= CNT_RST;
      diag_active_o <= 1'b0;
      dev_mode_o <= DEV_STBY_DLY;
    end else begin
      state <= next_state;
      dly_cnt <= next_dly_cnt;
      diag_active_o <= next_diag;
      dev_mode_o <= next_state;
    end
  end

  // Sticky events; a set in the clear cycle survives
  always_comb begin
    stby_evt = (state == DEV_STBY_DLY) && (next_state == DEV_STANDBY);
    irq_evt = '0;
    irq_evt[IRQ_FLT_LSB +: 2] = ch_fevt;
    irq_evt[IRQ_RETRY_LSB +: 2] = ch_revt;
    irq_evt[IRQ_STBY_BIT] = stby_evt;
    irq_clr = '0;
    next_irq_enable = irq_enable;
    next_chan_mask = chan_mask;
    if (reg_wr_i && reg_addr_i == REG_IRQ_CLEAR) begin
      irq_clr = reg_wdata_i[IRQ_W-1:0];
    end else if (reg_wr_i && reg_addr_i == REG_IRQ_ENABLE) begin
      next_irq_enable = reg_wdata_i[IRQ_W-1:0];
    end else if (reg_wr_i && reg_addr_i == REG_CONFIG) begin
      next_chan_mask = reg_wdata_i[1:0];
    end
    next_irq_status = (irq_status & ~irq_clr) | irq_evt;
    next_irq = |(next_irq_status & next_irq_enable);
  end

  // Read data stands one cycle after the strobe only
  always_comb begin
    next_rdata = 32'h00000000;
    if (reg_rd_i && reg_addr_i == REG_MODE) begin
      next_rdata[MODE_STATE_LSB +: 3] = state;
      next_rdata[MODE_SW_LSB +: 2] = sw;
      next_rdata[MODE_FLT_LSB +: 2] = chan_flt;
      next_rdata[MODE_DIAG_BIT] = diag_active_o;
    end else if (reg_rd_i && reg_addr_i == REG_IRQ_STATUS) begin
      next_rdata[IRQ_W-1:0] = irq_status;
    end else if (reg_rd_i && reg_addr_i == REG_IRQ_ENABLE) begin
      next_rdata[IRQ_W-1:0] = irq_enable;
    end else if (reg_rd_i && reg_addr_i == REG_CONFIG) begin
      next_rdata[1:0] = chan_mask;
    end
  end

  // Register file and interrupt line
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_status <= '0;
      irq_enable <= IRQ_ENABLE_RST;
      chan_mask <= CHAN_MASK_RST;
      irq_o <= 1'b0;
      reg_rdata_o <= 32'h00000000;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      chan_mask <= next_chan_mask;
      irq_o <= next_irq;
      reg_rdata_o <= next_rdata;
    end
  end

  // Channel outputs pass straight from the channel flops
  assign switch_on_o = sw;
  assign chan_fault_o = chan_flt;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  property p_stby_no_diag;
    state == DEV_STANDBY |-> !diag_active_o;
  endproperty
  a_stby_no_diag: assert property (p_stby_no_diag)
    else $error("diagnostics active in standby");

  property p_diag_sw_off;
    state == DEV_DIAG |-> diag_active_o && sw == 2'b00;
  endproperty
  a_diag_sw_off: assert property (p_diag_sw_off)
    else $error("diag state with switch on or diag off");

  property p_enter_dly;
    all_low && !dev_quiet(state) |=> state == DEV_STBY_DLY
      && dly_cnt == CNT_RST;
  endproperty
  a_enter_dly: assert property (p_enter_dly)
    else $error("standby delay not entered");

  property p_stby_after_dly;
    $rose(state == DEV_STANDBY) |-> $past(all_low) && $past(dly_done)
      && $past(state == DEV_STBY_DLY);
  endproperty
  a_stby_after_dly: assert property (p_stby_after_dly)
    else $error("standby entered early");

  property p_active;
    en_eff != 2'b00 |=> state == DEV_ACTIVE;
  endproperty
  a_active: assert property (p_active)
    else $error("not active with a channel enabled");

  property p_diag_in_active;
    state == DEV_ACTIVE && en_eff != 2'b00 |=> state == DEV_ACTIVE
      && diag_active_o == $past(pins_s.diag_on);
  endproperty
  a_diag_in_active: assert property (p_diag_in_active)
    else $error("diag toggle disturbed active");

  property p_other_chan;
    sw[1] && en_eff[1] && !pins_s.thermal[1] && !pins_s.ilim[1]
      |=> sw[1];
  endproperty
  a_other_chan: assert property (p_other_chan)
    else $error("second channel disturbed");

  property p_wake;
    dev_quiet(state) && en_eff == 2'b00 && pins_s.diag_on
      |=> state == DEV_DIAG;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake from standby");

  c_standby: cover property (state == DEV_STANDBY);
  c_diag: cover property (state == DEV_DIAG && diag_active_o);
  c_irq: cover property ($rose(irq_o));

endmodule // dual_switch_mode_controller

// [test/host_model.sv]
// Host microcontroller model: drives the enable, diag and latch pins.
// Assumes the bench hands it pin requests on the system clock.
`timescale 1ns/1ps
module host_model
  import dsm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Requested pin levels
  input wire pins_t cmd_i,
  // Device pins
  output logic chan_one_on_o,
  output logic chan_two_on_o,
  output logic diag_on_o,
  output logic latch_sel_o,
  output logic [1:0] thermal_o,
  output logic [1:0] cur_limit_o
);
  // Pins change only after an edge, like a real port register
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      chan_one_on_o <= 1'b0;
      chan_two_on_o <= 1'b0;
      diag_on_o <= 1'b0;
      latch_sel_o <= 1'b0;
      thermal_o <= 2'h0;
      cur_limit_o <= 2'h0;
    end else begin
      chan_one_on_o <= cmd_i.chan_on_input[0];
      chan_two_on_o <= cmd_i.chan_on_input[1];
      diag_on_o <= cmd_i.diag_on; // Free to toggle in Active
      latch_sel_o <= cmd_i.latch_sel;
      thermal_o <= cmd_i.thermal;
      cur_limit_o <= cmd_i.ilim;
    end
  end
endmodule // host_model

// [test/testbench.sv]
// Self-checking bench of the mode controller with a host pin model.
// Assumes short delay and retry counts; reads queue their expectations.
`timescale 1ns/1ps
module testbench
  import dsm_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  pins_t cmd = '0;
  logic ch1, ch2, dg, lt;
  logic [1:0] th, il;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h00000000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [1:0] switch_on_o, chan_fault_o;
  logic diag_active_o, irq_o, rd_d;
  logic [2:0] dev_mode_o;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h000125E6;
  int n_fail = 0;
  int comparisons = 0;
  logic [31:0] pins_seen;

  // Status pins share the mode register layout
  assign pins_seen = {24'h000000, diag_active_o, chan_fault_o, switch_on_o,
                      dev_mode_o};

  always #4 clk_sys_i = ~clk_sys_i;

  host_model host (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .cmd_i(cmd), .chan_one_on_o(ch1), .chan_two_on_o(ch2),
    .diag_on_o(dg), .latch_sel_o(lt), .thermal_o(th), .cur_limit_o(il));

  dual_switch_mode_controller #(.STBY_DELAY_CYCLES(8), .RETRY_CYCLES(4))
  dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .chan_one_on_i(ch1), .chan_two_on_i(ch2), .diag_on_i(dg),
    .latch_sel_i(lt), .thermal_sd_i(th), .cur_limit_i(il),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .switch_on_o(switch_on_o), .chan_fault_o(chan_fault_o),
    .diag_active_o(diag_active_o), .dev_mode_o(dev_mode_o), .irq_o(irq_o));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic done(input string name);
    $display("Test %s done", name);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    // Pins show the same flops the mode read will sample
    if (a == REG_MODE) begin
      @(negedge clk_sys_i);
      check("pins", pins_seen, e);
    end
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask

  // Pin request, then enough edges for model, sync and state flop
  task automatic pins(input logic [1:0] en, input logic d, input logic l,
                      input logic [1:0] t, input logic [1:0] c, input int n);
    @(posedge clk_sys_i);
    cmd <= '{latch_sel: l, diag_on: d, chan_on_input: en, thermal: t,
             ilim: c};
    cyc(n);
  endtask

  task automatic irq_is(input logic e);
    cyc(2);
    // Settled level, away from the launching edge
    @(negedge clk_sys_i);
    check("irq", {31'h0, irq_o}, {31'h0, e});
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys_i) rd_d <= reg_rd_i;
  always @(negedge clk_sys_i) begin
    if (rd_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("read queue", 32'h0, 32'h1);
      end else begin
        check("read data", reg_rdata_o, exp_q.pop_front());
      end
    end
  end

  // Watchdog so a hang still reaches the verdict
  initial begin
    cyc(20000);
    n_fail++;
    $display("[FAIL] run length expected end seen hang");
    finish_test;
  end

  initial begin
    cyc(4);
    sys_rst_i <= 1'b0;
    rd(REG_MODE, 32'h00000001);
    rd(8'h14, 32'h00000000);
    cyc(20);
    rd(REG_MODE, 32'h00000000);
    rd(REG_IRQ_STATUS, 32'h00000010);
    rd(REG_IRQ_ENABLE, 32'h00000000);
    wr(REG_IRQ_ENABLE, 32'h00000010);
    irq_is(1'b1);
    seed = lfsr(seed);
    wr(REG_IRQ_STATUS, seed);
    wr(REG_MODE, lfsr(seed));
    rd(REG_IRQ_STATUS, 32'h00000010);
    rd(REG_MODE, 32'h00000000);
    wr(REG_IRQ_CLEAR, 32'h0000001F);
    irq_is(1'b0);
    rd(REG_IRQ_STATUS, 32'h00000000);
    done("standby");
    // Diag alone, then a channel before the delay ends
    pins(2'h0, 1'b1, 1'b0, 2'h0, 2'h0, 6);
    rd(REG_MODE, 32'h00000082);
    pins(2'h0, 1'b0, 1'b0, 2'h0, 2'h0, 5);
    rd(REG_MODE, 32'h00000001);
    pins(2'h1, 1'b0, 1'b0, 2'h0, 2'h0, 6);
    rd(REG_MODE, 32'h0000000B);
    done("wake");
    pins(2'h3, 1'b0, 1'b0, 2'h0, 2'h0, 6);
    rd(REG_MODE, 32'h0000001B);
    pins(2'h3, 1'b1, 1'b0, 2'h0, 2'h0, 6);
    rd(REG_MODE, 32'h0000009B);
    pins(2'h3, 1'b0, 1'b0, 2'h0, 2'h0, 6);
    rd(REG_MODE, 32'h0000001B);
    pins(2'h1, 1'b0, 1'b0, 2'h0, 2'h0, 6);
    rd(REG_MODE, 32'h0000000B);
    done("active");
    // Latched thermal fault on the first channel
    pins(2'h3, 1'b0, 1'b1, 2'h1, 2'h0, 3);
    pins(2'h3, 1'b0, 1'b1, 2'h0, 2'h0, 4);
    rd(REG_MODE, 32'h00000033);
    cyc(20);
    rd(REG_MODE, 32'h00000033);
    rd(REG_IRQ_STATUS, 32'h00000001);
    wr(REG_IRQ_ENABLE, 32'h00000005);
    irq_is(1'b1);
    pins(2'h3, 1'b0, 1'b0, 2'h0, 2'h0, 12);
    rd(REG_MODE, 32'h0000001B);
    rd(REG_IRQ_STATUS, 32'h00000005);
    wr(REG_IRQ_CLEAR, 32'h0000001F);
    done("latched fault");
    // Current limit on the second channel, enable dropped meanwhile
    pins(2'h3, 1'b0, 1'b0, 2'h0, 2'h2, 6);
    rd(REG_MODE, 32'h0000004B);
    pins(2'h1, 1'b0, 1'b0, 2'h0, 2'h0, 14);
    rd(REG_MODE, 32'h0000000B);
    rd(REG_IRQ_STATUS, 32'h0000000A);
    irq_is(1'b0);
    wr(REG_IRQ_ENABLE, 32'h00000008);
    irq_is(1'b1);
    wr(REG_IRQ_CLEAR, 32'h0000001F);
    irq_is(1'b0);
    done("retry");
    // Channel mask keeps the second channel off
    rd(REG_CONFIG, 32'h00000003);
    seed = lfsr(seed);
    wr(REG_CONFIG, {seed[31:2], 2'h1});
    rd(REG_CONFIG, 32'h00000001);
    pins(2'h3, 1'b0, 1'b0, 2'h0, 2'h0, 6);
    rd(REG_MODE, 32'h0000000B);
    pins(2'h0, 1'b0, 1'b0, 2'h0, 2'h0, 20);
    rd(REG_MODE, 32'h00000000);
    rd(REG_IRQ_STATUS, 32'h00000010);
    cyc(3);
    done("mask and idle");
    finish_test;
  end
endmodule // testbench
